// ---- rtl/sfp_pkg.sv ----
// Shared constants and types of the serial flash command front end.
package sfp_pkg;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int              ARRAY_ADDR_BITS = 25;
  localparam int              BLOCK_BITS      = 9;
  localparam logic [9:0]      BLOCK_COUNT     = 10'h200;
  localparam logic [9:0]      BLOCK_ONE       = 10'h001;
  localparam logic [3:0]      BP_NONE         = 4'h0;
  localparam logic [3:0]      BP_ALL_FROM     = 4'hA;
  localparam logic [7:0]      EXT_ADDR_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // Link, crossing and buffering
  // ----------------------------------------------------------------------
  localparam int              FIFO_WIDTH      = 9;
  localparam int              FIFO_DEPTH      = 16;
  localparam int              SYNC_WIDTH      = 3;
  localparam logic [2:0]      SYNC_RESET      = 3'h2;
  localparam logic [2:0]      ADDR_BYTES_3    = 3'h3;
  localparam logic [2:0]      ADDR_BYTES_4    = 3'h4;
  localparam logic [1:0]      PAIRS_PER_BYTE  = 2'h3;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_READ        = 8'h03;
  localparam logic [7:0] OPC_READ_4B     = 8'h13;
  localparam logic [7:0] OPC_FAST        = 8'h0B;
  localparam logic [7:0] OPC_FAST_4B     = 8'h0C;
  localparam logic [7:0] OPC_PROG        = 8'h02;
  localparam logic [7:0] OPC_PROG_4B     = 8'h12;
  localparam logic [7:0] OPC_ERASE_4K    = 8'h20;
  localparam logic [7:0] OPC_ERASE_4K_4B = 8'h21;
  localparam logic [7:0] OPC_ERASE_32K   = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K   = 8'hD8;
  localparam logic [7:0] OPC_ERASE_64K4B = 8'hDC;
  localparam logic [7:0] OPC_CHIP_ERASE  = 8'hC7;
  localparam logic [7:0] OPC_CHIP_ERASE2 = 8'h60;
  localparam logic [7:0] OPC_ENTER_4B    = 8'hB7;
  localparam logic [7:0] OPC_EXIT_4B     = 8'hE9;
  localparam logic [7:0] OPC_ENTER_QUAD  = 8'h38;
  localparam logic [7:0] OPC_EXIT_QUAD   = 8'hFF;
  localparam logic [7:0] OPC_RESET_EN    = 8'h66;
  localparam logic [7:0] OPC_RESET       = 8'h99;
  localparam logic [7:0] OPC_WRITE_EXT   = 8'hC5;

  typedef enum logic [4:0] {
    ST_OPC   = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_SKIP  = 5'b01000,
    ST_ISSUE = 5'b10000
  } sfp_state_type;

endpackage

// ---- rtl/sfp_sync.sv ----
// Two-flop level synchroniser for a group of independent bits.
`timescale 1ns/1ps
module sfp_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import sfp_pkg::*;

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  if (WIDTH < 1) begin : g_chk
    $error("sfp_sync needs at least one bit");
  end

  // The first stage feeds nothing but the second one.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage1_ff <= RESET_VALUE;
      stage2_ff <= RESET_VALUE;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule

// ---- rtl/sfp_fifo.sv ----
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module sfp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import sfp_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             full;
  logic             empty;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("sfp_fifo depth must be a power of two of at least 2");
  end

  assign empty     = (wr_ptr_ff == rd_ptr_ff);
  assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/sfp_frontend.sv ----
// Command front end of a serial NOR flash: framing, addressing and protection.
//
// Overview of operation
// R1: With the complement bit set, value 0000 protects all, 110x and 1x1x protect nothing, others protect the complement of the plain region.
// R2: Under the complement bit, top/bottom zero puts the protected span low and one puts it high.
// R3: A program or erase whose target touches a protected part is dropped and memory is untouched.
// R4: The extended address byte is applied only while the device is in 3-byte mode.
// R5: In 3-byte mode, extended bit 24 picks the lower or the upper 128Mb half.
// R6: After power-up with the power-up mode bit set or after enter-4-byte, four address bytes are taken and the extended byte is ignored.
// R7: Any command carrying a four-byte address loads its top byte into the extended address byte.
// R8: The extended address byte clears to zero at power-up and on software or hardware reset.
// R9: A falling chip select starts an instruction and its first byte is the opcode.
// R10: In single-line mode the input is sampled on the rising clock, most significant bit first.
// R11: In four-line mode every phase uses four lines, one byte per two clocks, high nibble first.
// R12: The host ends an instruction by raising chip select; reads may end after any bit.
// R13: Write, program and erase instructions not ending on a whole byte are ignored.
// R14: While an array operation is busy, everything except read status is ignored.
// R15: A read-only flag shows zero in 3-byte mode and one in 4-byte mode.
// R16: The non-volatile power-up mode bit picks 4-byte mode at power-on or reset when set, 3-byte when clear.
// R17: In 3-byte mode the effective address is the extended byte prefixed to the 24 received bits.
`timescale 1ns/1ps
module sfp_frontend
  import sfp_pkg::*;
#(
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        serial_clock,
  input  wire logic        chip_select_n,
  input  wire logic        serial_data_in,
  input  wire logic [2:0]  io_upper_in,
  input  wire logic        protect_complement,
  input  wire logic        top_bottom_select,
  input  wire logic [3:0]  block_protect,
  input  wire logic        powerup_addr_mode_bit,
  input  wire logic        array_busy,
  input  wire logic        cmd_ready,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [24:0]      cmd_addr,
  output logic             data_strobe,
  output logic [7:0]       data_byte,
  output logic             cmd_dropped,
  output logic             current_addr_mode_flag,
  output logic             four_line_command_mode,
  output logic             upper_half_select,
  output logic [7:0]       ext_addr,
  output logic             fifo_overflow
);

  // ----------------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------------
  function automatic logic is_read_op(input logic [7:0] op);
    return op == OPC_READ || op == OPC_READ_4B || op == OPC_FAST || op == OPC_FAST_4B;
  endfunction

  function automatic logic is_prog_op(input logic [7:0] op);
    return op == OPC_PROG || op == OPC_PROG_4B;
  endfunction

  function automatic logic is_chip_erase(input logic [7:0] op);
    return op == OPC_CHIP_ERASE || op == OPC_CHIP_ERASE2;
  endfunction

  function automatic logic is_4b_op(input logic [7:0] op);
    return op == OPC_READ_4B || op == OPC_FAST_4B || op == OPC_PROG_4B ||
           op == OPC_ERASE_4K_4B || op == OPC_ERASE_64K4B;
  endfunction

  function automatic logic is_erase_op(input logic [7:0] op);
    return op == OPC_ERASE_4K || op == OPC_ERASE_4K_4B || op == OPC_ERASE_32K ||
           op == OPC_ERASE_64K || op == OPC_ERASE_64K4B;
  endfunction

  function automatic logic is_plain_op(input logic [7:0] op);
    return is_chip_erase(op) || op == OPC_ENTER_4B || op == OPC_EXIT_4B ||
           op == OPC_ENTER_QUAD || op == OPC_EXIT_QUAD || op == OPC_RESET_EN ||
           op == OPC_RESET || op == OPC_WRITE_EXT;
  endfunction

  // Every sector and block erase fits inside one 64KB block, so a block test covers it.
  function automatic logic block_protected(input logic [BLOCK_BITS-1:0] blk,
                                           input logic cmp,
                                           input logic tb,
                                           input logic [3:0] bp);
    logic [9:0] size;
    logic       hit;
    size = BLOCK_ONE << (bp - 4'h1);
    if (bp == BP_NONE) begin
      hit = 1'b0;
    end else if (bp >= BP_ALL_FROM) begin
      hit = 1'b1;
    end else if (tb) begin
      hit = ({1'b0, blk} < size);
    end else begin
      hit = ({1'b0, blk} >= (BLOCK_COUNT - size));
    end
    return hit ^ cmp; // R1 R2
  endfunction

  // ----------------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------------
  // The serial clock only runs inside frames, so a pair of edges is the
  // unit handed over; it serves both line widths and keeps mode decisions
  // in the core domain.
  logic       link_rst_ff;
  logic       frame_clear;
  logic       half_ff;
  logic       odd_ff;
  logic [3:0] first_nib_ff;
  logic [7:0] pair_ff;
  logic       pair_tgl_ff;
  logic [3:0] io_now;

  always_ff @(posedge clock) begin
    link_rst_ff <= !rstn;
  end

  assign frame_clear = chip_select_n | link_rst_ff;
  assign io_now      = {io_upper_in, serial_data_in};

  always_ff @(posedge serial_clock or posedge frame_clear) begin
    if (frame_clear) begin
      half_ff <= 1'b0; // R9
    end else begin
      half_ff <= !half_ff;
    end
  end

  always_ff @(posedge serial_clock or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      odd_ff       <= 1'b0;
      first_nib_ff <= '0;
      pair_ff      <= '0;
      pair_tgl_ff  <= 1'b0;
    end else begin
      odd_ff <= !half_ff;
      if (!half_ff) begin
        first_nib_ff <= io_now; // R10 R11
      end else begin
        pair_ff     <= {first_nib_ff, io_now}; // R11
        pair_tgl_ff <= !pair_tgl_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossing into the core domain
  // ----------------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] sync_q;
  logic                  tgl_d_ff;
  logic                  cs_d_ff;
  logic                  eof_pend_ff;
  logic                  pair_evt;
  logic                  cs_rise;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic [FIFO_WIDTH-1:0] fifo_in_data;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [FIFO_WIDTH-1:0] word;

  sfp_sync #(
    .WIDTH       (SYNC_WIDTH),
    .RESET_VALUE (SYNC_RESET)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({odd_ff, chip_select_n, pair_tgl_ff}),
    .sync_out (sync_q)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tgl_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
    end else begin
      tgl_d_ff <= sync_q[0];
      cs_d_ff  <= sync_q[1];
    end
  end

  assign pair_evt = sync_q[0] ^ tgl_d_ff;
  assign cs_rise  = sync_q[1] & !cs_d_ff;

  // The pair register holds still for two serial clocks after its toggle,
  // well past the synchroniser delay, so the core reads it directly.
  assign fifo_in_valid = pair_evt | eof_pend_ff;
  assign fifo_in_data  = pair_evt ? {1'b0, pair_ff} : {1'b1, 7'h00, sync_q[2]};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      eof_pend_ff <= 1'b0;
    end else if (cs_rise) begin
      eof_pend_ff <= 1'b1;
    end else if (!pair_evt && fifo_in_ready) begin
      eof_pend_ff <= 1'b0;
    end
  end

  // The link cannot be paused, so a full buffer loses pairs and says so.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      fifo_overflow <= 1'b0;
    end else if (fifo_in_valid && !fifo_in_ready) begin
      fifo_overflow <= 1'b1;
    end
  end

  sfp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (word)
  );

  // ----------------------------------------------------------------------
  // Byte assembly
  // ----------------------------------------------------------------------
  sfp_state_type state_ff;
  logic [7:0]    acc_ff;
  logic [1:0]    acc_cnt_ff;
  logic          pop;
  logic          got_byte;
  logic          frame_end;
  logic          frame_partial;
  logic [7:0]    byte_val;

  assign fifo_out_ready = (state_ff != ST_ISSUE);
  assign pop            = fifo_out_valid & fifo_out_ready;
  assign frame_end      = pop & word[8];
  assign got_byte       = pop & !word[8] & (four_line_command_mode | acc_cnt_ff == PAIRS_PER_BYTE);
  assign byte_val       = four_line_command_mode ? word[7:0]
                                                 : {acc_ff[5:0], word[4], word[0]}; // R10
  assign frame_partial  = word[0] | (!four_line_command_mode && acc_cnt_ff != 2'h0);

  always_ff @(posedge clock) begin
    if (!rstn || frame_end) begin
      acc_cnt_ff <= '0;
      acc_ff     <= '0;
    end else if (pop && !word[8] && !four_line_command_mode) begin
      acc_ff     <= {acc_ff[5:0], word[4], word[0]};
      acc_cnt_ff <= acc_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------
  logic [7:0]                 opcode_ff;
  logic [31:0]                addr_ff;
  logic [2:0]                 addr_left_ff;
  logic                       addr4_ff;
  logic                       data_seen_ff;
  logic [7:0]                 first_data_ff;
  logic                       ret_skip_ff;
  logic [31:0]                next_addr;
  logic [ARRAY_ADDR_BITS-1:0] eff_addr;
  logic [ARRAY_ADDR_BITS-1:0] eff_next;
  logic                       addr_done;
  logic                       commit;
  logic                       any_prot;
  logic                       target_prot;
  logic                       is_ep;
  logic                       issue_write;
  logic                       drop_write;
  logic                       issue_status;
  logic                       four_byte_ff;
  logic                       quad_ff;
  logic                       reset_en_ff;
  logic [7:0]                 ext_addr_ff;

  assign next_addr = {addr_ff[23:0], byte_val};
  assign eff_addr  = addr4_ff ? addr_ff[ARRAY_ADDR_BITS-1:0]
                              : {ext_addr_ff[0], addr_ff[23:0]}; // R4 R5 R17
  assign eff_next  = addr4_ff ? next_addr[ARRAY_ADDR_BITS-1:0]
                              : {ext_addr_ff[0], next_addr[23:0]}; // R4 R5 R6 R17
  assign addr_done = got_byte && state_ff == ST_ADDR && addr_left_ff == 3'h1;
  assign commit    = frame_end && state_ff == ST_DATA && !frame_partial; // R13
  assign any_prot  = protect_complement ? (block_protect < BP_ALL_FROM)
                                        : (block_protect != BP_NONE); // R1
  assign target_prot = is_chip_erase(opcode_ff) ? any_prot
                     : block_protected(eff_addr[ARRAY_ADDR_BITS-1 -: BLOCK_BITS],
                                       protect_complement, top_bottom_select, block_protect);
  assign is_ep       = is_erase_op(opcode_ff) || is_chip_erase(opcode_ff) ||
                       (is_prog_op(opcode_ff) && data_seen_ff);
  assign issue_write = commit && is_ep && !target_prot;
  assign drop_write  = commit && is_ep && target_prot; // R3
  assign issue_status = got_byte && state_ff == ST_OPC && byte_val == OPC_READ_STATUS;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff      <= ST_OPC;
      opcode_ff     <= '0;
      addr_ff       <= '0;
      addr_left_ff  <= '0;
      addr4_ff      <= 1'b0;
      data_seen_ff  <= 1'b0;
      first_data_ff <= '0;
      ret_skip_ff   <= 1'b0;
    end else begin
      case (state_ff)
        ST_OPC: begin
          if (got_byte) begin
            opcode_ff <= byte_val; // R9
            if (array_busy && byte_val != OPC_READ_STATUS) begin
              state_ff <= ST_SKIP; // R14
            end else if (byte_val == OPC_READ_STATUS) begin
              state_ff    <= ST_ISSUE;
              ret_skip_ff <= 1'b1;
            end else if (is_read_op(byte_val) || is_prog_op(byte_val) ||
                         is_erase_op(byte_val)) begin
              state_ff <= ST_ADDR;
              addr4_ff <= four_byte_ff || is_4b_op(byte_val); // R6
              addr_left_ff <= (four_byte_ff || is_4b_op(byte_val)) ? ADDR_BYTES_4
                                                                   : ADDR_BYTES_3; // R6
            end else if (is_plain_op(byte_val)) begin
              state_ff <= ST_DATA;
            end else begin
              state_ff <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (frame_end) begin
            state_ff <= ST_OPC; // R12 R13
          end else if (got_byte) begin
            addr_ff      <= next_addr;
            addr_left_ff <= addr_left_ff - 3'h1;
            if (addr_done) begin
              state_ff    <= is_read_op(opcode_ff) ? ST_ISSUE : ST_DATA;
              ret_skip_ff <= 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (frame_end) begin
            state_ff     <= issue_write ? ST_ISSUE : ST_OPC;
            ret_skip_ff  <= 1'b0;
            data_seen_ff <= 1'b0;
          end else if (got_byte && !data_seen_ff) begin
            first_data_ff <= byte_val;
            data_seen_ff  <= 1'b1;
          end
        end
        ST_SKIP: begin
          if (frame_end) begin
            state_ff <= ST_OPC; // R12
          end
        end
        ST_ISSUE: begin
          if (cmd_ready) begin
            state_ff <= ret_skip_ff ? ST_SKIP : ST_OPC;
          end
        end
        default: begin
          state_ff <= ST_OPC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Address and line modes
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      four_byte_ff <= powerup_addr_mode_bit; // R16
      quad_ff      <= 1'b0;
      ext_addr_ff  <= EXT_ADDR_RESET; // R8
      reset_en_ff  <= 1'b0;
    end else if (commit) begin
      reset_en_ff <= (opcode_ff == OPC_RESET_EN);
      case (opcode_ff)
        OPC_ENTER_4B:   four_byte_ff <= 1'b1; // R6
        OPC_EXIT_4B:    four_byte_ff <= 1'b0;
        OPC_ENTER_QUAD: quad_ff      <= 1'b1;
        OPC_EXIT_QUAD:  quad_ff      <= 1'b0;
        OPC_WRITE_EXT: begin
          if (data_seen_ff) begin
            ext_addr_ff <= first_data_ff;
          end
        end
        OPC_RESET: begin
          if (reset_en_ff) begin
            four_byte_ff <= powerup_addr_mode_bit; // R16
            quad_ff      <= 1'b0;
            ext_addr_ff  <= EXT_ADDR_RESET; // R8
          end
        end
        default: begin
          quad_ff <= quad_ff;
        end
      endcase
    end else if (addr_done && addr4_ff) begin
      ext_addr_ff <= next_addr[31:24]; // R7
    end
  end

  assign current_addr_mode_flag = four_byte_ff; // R15
  assign four_line_command_mode = quad_ff;
  assign upper_half_select      = ext_addr_ff[0];
  assign ext_addr               = ext_addr_ff;

  // ----------------------------------------------------------------------
  // Array-side outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_code  <= '0;
      cmd_addr  <= '0;
    end else if (issue_status) begin
      cmd_valid <= 1'b1;
      cmd_code  <= byte_val;
      cmd_addr  <= '0;
    end else if (addr_done && is_read_op(opcode_ff)) begin
      cmd_valid <= 1'b1;
      cmd_code  <= opcode_ff;
      cmd_addr  <= eff_next; // R5 R17
    end else if (issue_write) begin
      cmd_valid <= 1'b1;
      cmd_code  <= opcode_ff;
      cmd_addr  <= eff_addr;
    end else if (cmd_ready) begin
      cmd_valid <= 1'b0;
    end
  end

  // Page data is streamed as it arrives; only the final commit makes the
  // array write it, so a refused program leaves memory untouched.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      data_strobe <= 1'b0;
      data_byte   <= '0;
      cmd_dropped <= 1'b0;
    end else begin
      data_strobe <= got_byte && state_ff == ST_DATA && is_prog_op(opcode_ff);
      cmd_dropped <= drop_write; // R3
      if (got_byte) begin
        data_byte <= byte_val;
      end
    end
  end

endmodule

// ---- verification/sfp_frontend_monitor.sv ----
// Port checks of the flash command front end.
`timescale 1ns/1ps
module sfp_frontend_monitor (
  input wire logic        clock, rstn, cmd_valid, cmd_ready, data_strobe, cmd_dropped,
  input wire logic        array_busy, fifo_overflow, upper_half_select,
  input wire logic        current_addr_mode_flag, powerup_addr_mode_bit,
  input wire logic [7:0]  cmd_code, ext_addr,
  input wire logic [24:0] cmd_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_addr); endproperty
  a_hold: assert property (p_hold) else $error("command not held");
  property p_half; upper_half_select == ext_addr[0]; endproperty
  a_half: assert property (p_half) else $error("half select differs");
  property p_rst;
    $rose(rstn) |-> ext_addr == 8'h00 && current_addr_mode_flag == powerup_addr_mode_bit;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_strobe; data_strobe |=> !data_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  property p_drop; cmd_dropped |-> !cmd_valid ##1 !cmd_dropped; endproperty
  a_drop: assert property (p_drop) else $error("drop pulse wrong");
  property p_busy; $rose(cmd_valid) && array_busy |-> cmd_code == 8'h05; endproperty
  a_busy: assert property (p_busy) else $error("command while busy");
  property p_ovf; fifo_overflow |=> fifo_overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not sticky");
  property p_addr;
    cmd_valid && !(cmd_code inside {8'h05, 8'hC7, 8'h60}) |-> cmd_addr[24] == ext_addr[0];
  endproperty
  a_addr: assert property (p_addr) else $error("address top bit wrong");
endmodule
bind sfp_frontend sfp_frontend_monitor mon (.*);

// ---- verification/sfp_host.sv ----
// Host controller model that frames commands on the flash link.
`timescale 1ns/1ps
module sfp_host (
  output logic       sck,
  output logic       csn,
  output logic [3:0] io
);
  initial {sck, csn, io} = 6'h15;
  task automatic frame(input bit q, input logic [7:0] b[$], input int t);
    int n;
    int k;
    logic [7:0] u;
    n = q ? 2 : 8;
    #37 csn = 0;
    for (int e = 0; e < b.size() * n + t; e++) begin
      u = e / n < b.size() ? b[e / n] : 8'h00;
      k = n - 1 - e % n;
      io = q ? u[4 * k +: 4] : {~io[3:1], u[k]};
      #62.5 sck = 1;
      #62.5 sck = 0;
    end
    #60 csn = 1;
    // Released lines flip so a stale value is never mistaken for data.
    io = ~io;
    #250;
  endtask
endmodule

// ---- verification/sfp_frontend_bench.sv ----
// Self-checking bench of the flash command front end.
`timescale 1ns/1ps
module sfp_frontend_bench;
  logic clock = 0, rstn = 0, protect_complement = 0, top_bottom_select = 0, hold = 0;
  logic powerup_addr_mode_bit = 0, array_busy = 0, cmd_ready = 0;
  logic [3:0] block_protect = 0, io;
  logic serial_clock, chip_select_n, cmd_valid, data_strobe, cmd_dropped, fifo_overflow;
  logic current_addr_mode_flag, four_line_command_mode, upper_half_select;
  logic [7:0] cmd_code, data_byte, ext_addr, fq[$];
  logic [24:0] cmd_addr;
  wire serial_data_in = io[0];
  wire [2:0] io_upper_in = io[3:1];
  int mismatches, checks, got;
  int unsigned seed = 45, r;
  sfp_frontend #(.BUF_DEPTH(4)) dut (.*);
  sfp_host host (.sck(serial_clock), .csn(chip_select_n), .io(io));
  always #25 clock = ~clock;
  always @(posedge clock) #2 cmd_ready = !hold && xs() % 2;
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int prot(int blk);
    int n;
    n = block_protect == 0 ? 0 : block_protect >= 10 ? 512 : 1 << (block_protect - 1);
    return protect_complement ^ (top_bottom_select ? blk < n : blk >= 512 - n);
  endfunction
  task automatic ck(string s, logic [31:0] e, logic [31:0] v);
    checks++;
    if (v !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic go(bit q, logic [7:0] b[$], int t, int k, logic [24:0] a);
    got = 0;
    fork
      host.frame(q, b, t);
      repeat (300) @(posedge clock) if (!got && (cmd_valid || cmd_dropped)) begin
        got = cmd_valid ? 1 : 2;
        if (cmd_valid) ck("code", b[0], cmd_code);
        if (cmd_valid) ck("addr", a, cmd_addr);
      end
    join
    ck("kind", k, got);
    $display("frame %h done", b[0]);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000 mismatches++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clock);
    #2 rstn = 1;
    repeat (4) @(posedge clock);
    ck("mode", 0, current_addr_mode_flag);
    ck("ext", 0, ext_addr);
    go(0, '{8'hC5, 8'h01}, 0, 0, 0);
    ck("ext", 1, ext_addr);
    for (int i = 0; i < 20; i++) begin
      if (i == 10) go(0, '{8'h38}, 0, 0, 0);
      r = xs();
      #2 {top_bottom_select, block_protect} = r[4:0];
      protect_complement = i < 16 || r[5];
      go(i >= 10, '{8'h20, r[31:24], r[23:16], 8'h00}, 0, prot({1'b1, r[31:24]}) ? 2 : 1,
         {1'b1, r[31:16], 8'h00});
    end
    go(1, '{8'h20, 8'h00, 8'h00, 8'h00}, 1, 0, 0);
    go(1, '{8'h03, 8'h00, 8'h10, 8'h00}, 1, 1, 25'h100_1000);
    #2 array_busy = 1;
    go(1, '{8'h20, 8'h00, 8'h00, 8'h00}, 0, 0, 0);
    go(1, '{8'h05}, 0, 1, 0);
    #2 array_busy = 0;
    go(1, '{8'hFF}, 0, 0, 0);
    go(0, '{8'hB7}, 0, 0, 0);
    ck("mode", 1, current_addr_mode_flag);
    #2 block_protect = 0;
    protect_complement = 0;
    go(0, '{8'h20, 8'h02, 8'h00, 8'h30, 8'h00}, 0, 1, 25'h000_3000);
    ck("ext", 2, ext_addr);
    go(0, '{8'h66}, 0, 0, 0);
    go(0, '{8'h99}, 0, 0, 0);
    ck("ext", 0, ext_addr);
    ck("mode", 0, current_addr_mode_flag);
    go(0, '{8'h02, 8'h00, 8'h00, 8'h00, 8'h5A}, 0, 1, 0);
    ck("data", 8'h5A, data_byte);
    go(0, '{8'h38}, 0, 0, 0);
    ck("quad", 1, four_line_command_mode);
    #2 hold = 1;
    fq = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (12) fq.push_back(8'hA5);
    go(1, fq, 0, 1, 25'h000_0000);
    ck("ovf", 1, fifo_overflow);
    print_verdict();
  end
endmodule
